// ===== common/bbx_defines.svh
`ifndef BBX_DEFINES_SVH
`define BBX_DEFINES_SVH

// Region bounds
`define BBX_PERI_BB_LO     32'h4000_0000
`define BBX_PERI_BB_HI     32'h400F_FFFF
`define BBX_PERI_AL_LO     32'h4200_0000
`define BBX_PERI_AL_HI     32'h43FF_FFFF
`define BBX_SRAM_BB_LO     32'h2000_0000
`define BBX_SRAM_BB_HI     32'h200F_FFFF
`define BBX_SRAM_AL_LO     32'h2200_0000
`define BBX_SRAM_AL_HI     32'h23FF_FFFF

// Alias offset layout: byte index * 32 + bit index * 4
`define BBX_BIT_LSB        2
`define BBX_BIT_MSB        4
`define BBX_BYTE_LSB       5
`define BBX_BYTE_MSB       24

// Alias read answers
`define BBX_ALIAS_RD_CLR   32'h0000_0000
`define BBX_ALIAS_RD_SET   32'h0000_0001

`endif

// ===== common/bbx_pkg.sv
package bbx_pkg;

    typedef enum logic [1:0] {
        BBX_SZ_BYTE = 2'h0,
        BBX_SZ_HALF = 2'h1,
        BBX_SZ_WORD = 2'h2
    } bbx_size_t;

    typedef enum logic [2:0] {
        BBX_OP_READ  = 3'h0,
        BBX_OP_WRITE = 3'h1,
        BBX_OP_LDEX  = 3'h2,
        BBX_OP_STEX  = 3'h3,
        BBX_OP_FETCH = 3'h4
    } bbx_op_t;

    // Core side request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        bbx_size_t   size;
        bbx_op_t     op;
    } bbx_req_t;

    // Fabric side request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
        bbx_size_t   size;
        logic        write;
    } bbx_mreq_t;

endpackage

// ===== hdl/bbx_front.sv
`timescale 1ns/1ps
`include "bbx_defines.svh"
// Functional notes
// - Direct peripheral bit-band accesses pass as normal peripheral accesses.
// - Peripheral alias data accesses remap; writes become read, modify, write.
// - Instruction fetches into peripheral alias window are refused, not remapped.
// - Alias offset decodes as byte index times 32 plus bit index times 4.
// - Bit index selects one of eight bits in the target byte.
// - SRAM alias base 0x22000000 maps onto bit-band base 0x20000000.
// - Alias write copies write-data bit 0 into the target bit.
// - Alias write ignores write-data bits 31:1.
// - Alias read returns 0 when bit clear, 1 when set.
// - Words are little-endian: byte 0 at lowest address.
// - Load-exclusive returns data and sets the exclusive tag.
// - Store-exclusive status 0 on success with write, 1 on failure, no write.
// - Exclusive pairs work for word, halfword and byte sizes.
// - Clear-exclusive drops the tag.
// - Any store-exclusive drops the tag, pass or fail.
// - Taking an exception drops the tag.
// - Direct bit-band accesses keep their word, halfword or byte size.
module bbx_front (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Core request
    input  wire logic              core_req_valid,
    input  wire bbx_pkg::bbx_req_t core_req,
    output logic                   core_req_ready,
    // Core answer
    output logic                   core_rsp_valid,
    output logic [31:0]            core_rsp_rdata,
    output logic                   core_rsp_fault,
    // Monitor control
    input  wire logic              clear_exclusive_tag,
    input  wire logic              exception_taken,
    // Fabric request
    output logic                   mem_req_valid,
    output bbx_pkg::bbx_mreq_t     mem_req,
    input  wire logic              mem_req_ready,
    // Fabric answer
    input  wire logic              mem_rsp_valid,
    input  wire logic [31:0]       mem_rsp_rdata
);

    typedef enum logic [1:0] {
        BBX_ST_IDLE  = 2'b00,
        BBX_ST_REQ   = 2'b01,
        BBX_ST_WAIT  = 2'b11,
        BBX_ST_RESP  = 2'b10
    } bbx_state_t;

    // Decode of one core request
    typedef struct packed {
        logic        alias_hit;
        logic        fault;
        logic [31:0] base_addr;
        logic [2:0]  bit_idx;
    } bbx_dec_t;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Byte lanes of an access, little-endian
    function automatic logic [3:0] lane_mask(input logic [1:0] a, input bbx_pkg::bbx_size_t s);
        unique case (s)
            bbx_pkg::BBX_SZ_BYTE: lane_mask = 4'h1 << a;
            bbx_pkg::BBX_SZ_HALF: lane_mask = a[1] ? 4'hC : 4'h3;
            default:              lane_mask = 4'hF;
        endcase
    endfunction

    // Map an alias address to its bit-band byte and bit
    function automatic bbx_dec_t decode(input bbx_pkg::bbx_req_t r);
        bbx_dec_t    d;
        logic        peri;
        logic        sram;
        d = '0;
        peri = in_range(r.addr, `BBX_PERI_AL_LO, `BBX_PERI_AL_HI);
        sram = in_range(r.addr, `BBX_SRAM_AL_LO, `BBX_SRAM_AL_HI);
        d.bit_idx = r.addr[`BBX_BIT_MSB:`BBX_BIT_LSB];
        if (r.op == bbx_pkg::BBX_OP_FETCH) begin
            d.fault = peri;
        end else if (peri) begin
            d.alias_hit = 1'b1;
            d.base_addr = `BBX_PERI_BB_LO | {12'h000, r.addr[`BBX_BYTE_MSB:`BBX_BYTE_LSB]};
        end else if (sram) begin
            d.alias_hit = 1'b1;
            d.base_addr = `BBX_SRAM_BB_LO | {12'h000, r.addr[`BBX_BYTE_MSB:`BBX_BYTE_LSB]};
        end
        decode = d;
    endfunction

    bbx_state_t         state_reg;
    bbx_pkg::bbx_req_t  req_reg;
    bbx_dec_t           dec_reg;
    logic               rmw_reg;
    logic               excl_tag_reg;
    logic [31:0]        excl_addr_reg;
    logic               rsp_valid_reg;
    logic [31:0]        rsp_rdata_reg;
    logic               rsp_fault_reg;
    logic               mem_valid_reg;
    bbx_pkg::bbx_mreq_t mem_req_reg;
    bbx_dec_t           dec_now;
    logic               accept;
    logic               stex_ok;
    logic [7:0]         old_byte;
    logic [7:0]         new_byte;
    logic [1:0]         lane;

    assign dec_now = decode(core_req);
    assign core_req_ready = (state_reg == BBX_ST_IDLE);
    assign accept = core_req_valid && core_req_ready;
    assign stex_ok = excl_tag_reg && (excl_addr_reg == core_req.addr);
    assign lane = dec_reg.base_addr[1:0];
    assign old_byte = mem_rsp_rdata[8*lane +: 8];
    // Only bit 0 of write data reaches the target bit
    always_comb begin
        new_byte = old_byte;
        new_byte[dec_reg.bit_idx] = req_reg.wdata[0];
    end

    // Main sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= BBX_ST_IDLE;
            req_reg       <= '0;
            dec_reg       <= '0;
            rmw_reg       <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
            rsp_fault_reg <= 1'b0;
            mem_valid_reg <= 1'b0;
            mem_req_reg   <= '0;
        end else begin
            rsp_valid_reg <= 1'b0;
            unique case (state_reg)
                BBX_ST_IDLE: begin
                    if (accept) begin
                        req_reg <= core_req;
                        dec_reg <= dec_now;
                        rmw_reg <= 1'b0;
                        if (dec_now.fault) begin
                            rsp_valid_reg <= 1'b1;
                            rsp_fault_reg <= 1'b1;
                            rsp_rdata_reg <= '0;
                        end else if (core_req.op == bbx_pkg::BBX_OP_STEX && !stex_ok) begin
                            rsp_valid_reg <= 1'b1;
                            rsp_fault_reg <= 1'b0;
                            rsp_rdata_reg <= 32'h0000_0001;
                        end else begin
                            state_reg     <= BBX_ST_REQ;
                            mem_valid_reg <= 1'b1;
                            if (dec_now.alias_hit) begin
                                // Byte read first; a write follows as modify and write back
                                mem_req_reg.addr  <= dec_now.base_addr;
                                mem_req_reg.wdata <= '0;
                                mem_req_reg.strb  <= '0;
                                mem_req_reg.size  <= bbx_pkg::BBX_SZ_BYTE;
                                mem_req_reg.write <= 1'b0;
                                rmw_reg <= (core_req.op == bbx_pkg::BBX_OP_WRITE) ||
                                           (core_req.op == bbx_pkg::BBX_OP_STEX);
                            end else begin
                                // Direct pass-through keeps address and size
                                mem_req_reg.addr  <= core_req.addr;
                                mem_req_reg.wdata <= core_req.wdata;
                                mem_req_reg.strb  <= lane_mask(core_req.addr[1:0], core_req.size);
                                mem_req_reg.size  <= core_req.size;
                                mem_req_reg.write <= (core_req.op == bbx_pkg::BBX_OP_WRITE) ||
                                                     (core_req.op == bbx_pkg::BBX_OP_STEX);
                            end
                        end
                    end
                end
                BBX_ST_REQ: begin
                    if (mem_req_ready) begin
                        mem_valid_reg <= 1'b0;
                        state_reg     <= BBX_ST_WAIT;
                    end
                end
                BBX_ST_WAIT: begin
                    if (mem_rsp_valid) begin
                        if (rmw_reg) begin
                            // Write back the modified byte
                            rmw_reg           <= 1'b0;
                            mem_valid_reg     <= 1'b1;
                            mem_req_reg.write <= 1'b1;
                            mem_req_reg.wdata <= {4{new_byte}};
                            mem_req_reg.strb  <= 4'h1 << lane;
                            state_reg         <= BBX_ST_REQ;
                        end else begin
                            state_reg     <= BBX_ST_RESP;
                            rsp_valid_reg <= 1'b1;
                            rsp_fault_reg <= 1'b0;
                            if (req_reg.op == bbx_pkg::BBX_OP_STEX) begin
                                rsp_rdata_reg <= 32'h0000_0000;
                            end else if (dec_reg.alias_hit) begin
                                rsp_rdata_reg <= old_byte[dec_reg.bit_idx] ? `BBX_ALIAS_RD_SET
                                                                           : `BBX_ALIAS_RD_CLR;
                            end else begin
                                rsp_rdata_reg <= mem_rsp_rdata;
                            end
                        end
                    end
                end
                BBX_ST_RESP: begin
                    state_reg <= BBX_ST_IDLE;
                end
            endcase
        end
    end

    // Exclusive monitor tag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            excl_tag_reg  <= 1'b0;
            excl_addr_reg <= '0;
        end else if (clear_exclusive_tag || exception_taken) begin
            excl_tag_reg <= 1'b0;
        end else if (accept && core_req.op == bbx_pkg::BBX_OP_STEX) begin
            excl_tag_reg <= 1'b0;
        end else if (accept && core_req.op == bbx_pkg::BBX_OP_LDEX) begin
            excl_tag_reg  <= 1'b1;
            excl_addr_reg <= core_req.addr;
        end
    end

    assign core_rsp_valid = rsp_valid_reg;
    assign core_rsp_rdata = rsp_rdata_reg;
    assign core_rsp_fault = rsp_fault_reg;
    assign mem_req_valid  = mem_valid_reg;
    assign mem_req        = mem_req_reg;

    sequence seq_alias_write;
        accept && dec_now.alias_hit && core_req.op == bbx_pkg::BBX_OP_WRITE;
    endsequence

    // Monitor events as seen at the core request
    sequence seq_stex_taken;
        accept && core_req.op == bbx_pkg::BBX_OP_STEX;
    endsequence
    sequence seq_ldex_taken;
        accept && core_req.op == bbx_pkg::BBX_OP_LDEX;
    endsequence

    chk_fetch_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && core_req.op == bbx_pkg::BBX_OP_FETCH && dec_now.fault
        |=> core_rsp_valid && core_rsp_fault && !mem_req_valid)
        else $error("alias fetch not refused");
    chk_alias_first_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_alias_write |=> mem_req_valid && !mem_req.write && mem_req.size == bbx_pkg::BBX_SZ_BYTE)
        else $error("alias write did not start with read");
    chk_alias_addr_map: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && dec_now.alias_hit && (core_req.op != bbx_pkg::BBX_OP_STEX || stex_ok)
        |=> mem_req.addr[19:0] == $past(core_req.addr[24:5]))
        else $error("alias address mapping wrong");
    chk_sram_base: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && core_req.addr == `BBX_SRAM_AL_LO && core_req.op == bbx_pkg::BBX_OP_READ
        |=> mem_req.addr == `BBX_SRAM_BB_LO)
        else $error("sram alias base wrong");
    chk_alias_rd_val: assert property (@(posedge core_clk) disable iff (!rst_n)
        core_rsp_valid && dec_reg.alias_hit && req_reg.op == bbx_pkg::BBX_OP_READ |-> core_rsp_rdata[31:1] == 31'h0)
        else $error("alias read value not 0 or 1");
    chk_wb_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req_valid && mem_req.write && dec_reg.alias_hit
        |-> mem_req.wdata[8*lane + dec_reg.bit_idx] == req_reg.wdata[0])
        else $error("alias write-back bit wrong");
    chk_pass_size: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && !dec_now.alias_hit && !dec_now.fault && core_req.op == bbx_pkg::BBX_OP_READ
        |=> mem_req.size == $past(core_req.size) && mem_req.addr == $past(core_req.addr))
        else $error("pass-through changed access");
    chk_stex_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && core_req.op == bbx_pkg::BBX_OP_STEX |=> !excl_tag_reg)
        else $error("tag kept after store-exclusive");
    chk_clr_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        clear_exclusive_tag || exception_taken |=> !excl_tag_reg)
        else $error("tag kept after clear");
    chk_stex_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && core_req.op == bbx_pkg::BBX_OP_STEX && !stex_ok
        |=> core_rsp_valid && core_rsp_rdata == 32'h0000_0001 && !mem_req_valid)
        else $error("failed store-exclusive wrote");
    chk_stex_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_stex_taken ##0 stex_ok |=> mem_req_valid)
        else $error("granted store-exclusive did not reach fabric");
    chk_ldex_tag: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_ldex_taken ##0 (!clear_exclusive_tag && !exception_taken) |=> excl_tag_reg)
        else $error("load-exclusive did not set tag");
    chk_exc_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        exception_taken |=> !excl_tag_reg)
        else $error("tag kept after exception");
    chk_wb_lane: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req_valid && mem_req.write && dec_reg.alias_hit
        |-> mem_req.strb == (4'h1 << mem_req.addr[1:0]) && mem_req.size == bbx_pkg::BBX_SZ_BYTE)
        else $error("alias write-back lane wrong");
    chk_pass_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && !dec_now.alias_hit && !dec_now.fault && core_req.op == bbx_pkg::BBX_OP_WRITE
        |=> mem_req.write && mem_req.addr == $past(core_req.addr) && mem_req.wdata == $past(core_req.wdata))
        else $error("pass-through write changed");

endmodule

// ===== test/bbx_mem_model.sv
`timescale 1ns/1ps
// Fabric memory model: byte store, optional wait states before accepting
module bbx_mem_model (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Pacing
    input  wire logic               slow,
    // Fabric request
    input  wire logic               mem_req_valid,
    input  wire bbx_pkg::bbx_mreq_t mem_req,
    output logic                    mem_req_ready,
    // Fabric answer
    output logic                    mem_rsp_valid,
    output logic [31:0]             mem_rsp_rdata
);
    logic [7:0]  mem [bit [31:0]];
    logic [31:0] base;
    logic [31:0] rd;
    logic        pend;
    int          wait_cnt;

    // Accept after a wait, store by lane, answer on the following cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_ready <= 1'b0;
            mem_rsp_valid <= 1'b0;
            mem_rsp_rdata <= 32'h0000_0000;
            pend          <= 1'b0;
            wait_cnt      <= 0;
        end else begin
            mem_rsp_valid <= pend;
            mem_rsp_rdata <= pend ? rd : ~mem_rsp_rdata; // Released bus never holds its last value
            pend          <= 1'b0;
            mem_req_ready <= 1'b0;
            if (mem_req_valid && mem_req_ready) begin
                base = {mem_req.addr[31:2], 2'b00};
                for (int i = 0; i < 4; i++) begin
                    if (mem_req.write && mem_req.strb[i]) begin
                        mem[base + i] = mem_req.wdata[8*i +: 8];
                    end
                    rd[8*i +: 8] = mem.exists(base + i) ? mem[base + i] : 8'hA5;
                end
                pend     <= 1'b1;
                wait_cnt <= 0;
            end else if (mem_req_valid) begin
                wait_cnt      <= wait_cnt + 1;
                mem_req_ready <= (wait_cnt >= (slow ? 3 : 0));
            end
        end
    end
endmodule

// ===== test/bbx_front_tb.sv
`timescale 1ns/1ps
module bbx_front_tb;
    logic               core_clk, rst_n, core_req_valid, clear_exclusive_tag, exception_taken, slow;
    bbx_pkg::bbx_req_t  core_req;
    logic               core_req_ready, core_rsp_valid, core_rsp_fault;
    logic               mem_req_valid, mem_req_ready, mem_rsp_valid, flt;
    logic [31:0]        core_rsp_rdata, mem_rsp_rdata, rdat;
    bbx_pkg::bbx_mreq_t mem_req, last_req;
    int                 err_total, tests_run, n_req, n0;

    bbx_front u_dut (.core_clk(core_clk), .rst_n(rst_n), .core_req_valid(core_req_valid), .core_req(core_req),
        .core_req_ready(core_req_ready), .core_rsp_valid(core_rsp_valid), .core_rsp_rdata(core_rsp_rdata),
        .core_rsp_fault(core_rsp_fault), .clear_exclusive_tag(clear_exclusive_tag),
        .exception_taken(exception_taken), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_rdata(mem_rsp_rdata));
    bbx_mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .mem_req_valid(mem_req_valid),
        .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_rdata(mem_rsp_rdata));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // Record every fabric handshake
    always @(posedge core_clk) begin
        if (mem_req_valid && mem_req_ready) begin
            last_req <= mem_req;
            n_req    <= n_req + 1;
        end
    end

    // Compare helpers
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // One core access: hold until taken, then wait for the answer pulse
    task automatic access(input bbx_pkg::bbx_op_t op, input logic [31:0] a, input logic [31:0] w,
                          input bbx_pkg::bbx_size_t sz);
        int n;
        n = 0;
        @(posedge core_clk);
        core_req_valid <= 1'b1;
        core_req       <= '{addr: a, wdata: w, size: sz, op: op};
        @(negedge core_clk);
        while (!core_req_ready && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        core_req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!core_rsp_valid && n < 200);
        if (!core_rsp_valid) begin
            err_total++;
            $display("Error at %0t: no answer", $time);
        end
        rdat = core_rsp_rdata;
        flt  = core_rsp_fault;
    endtask

    // One-cycle pulse on a monitor control input
    task automatic pulse(input bit clr);
        @(posedge core_clk);
        if (clr) clear_exclusive_tag <= 1'b1;
        else exception_taken <= 1'b1;
        @(posedge core_clk);
        clear_exclusive_tag <= 1'b0;
        exception_taken     <= 1'b0;
    endtask

    // Direct bit-band accesses through a slow fabric
    task automatic t_direct;
        @(posedge core_clk);
        slow <= 1'b1;
        access(bbx_pkg::BBX_OP_WRITE, 32'h4000_0010, 32'h1122_3344, bbx_pkg::BBX_SZ_WORD);
        chk_data(last_req.addr, 32'h4000_0010);
        chk_data({28'h0, last_req.strb}, 32'h0000_000F);
        access(bbx_pkg::BBX_OP_WRITE, 32'h4000_0013, 32'hAAAA_AAAA, bbx_pkg::BBX_SZ_BYTE);
        chk_data({28'h0, last_req.strb}, 32'h0000_0008);
        chk_data({30'h0, last_req.size}, {30'h0, bbx_pkg::BBX_SZ_BYTE});
        access(bbx_pkg::BBX_OP_WRITE, 32'h4000_0016, 32'h5566_5566, bbx_pkg::BBX_SZ_HALF);
        chk_data({28'h0, last_req.strb}, 32'h0000_000C);
        access(bbx_pkg::BBX_OP_READ, 32'h4000_0010, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'hAA22_3344);
        @(posedge core_clk);
        slow <= 1'b0;
    endtask

    // Peripheral alias reads and read-modify-write updates
    task automatic t_alias;
        access(bbx_pkg::BBX_OP_READ, 32'h4200_0208, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0001);
        access(bbx_pkg::BBX_OP_READ, 32'h4200_020C, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0000);
        access(bbx_pkg::BBX_OP_READ, 32'h4200_027C, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0001);
        chk_data(last_req.addr, 32'h4000_0013);
        n0 = n_req;
        access(bbx_pkg::BBX_OP_WRITE, 32'h4200_0208, 32'hFFFF_FFFE, bbx_pkg::BBX_SZ_WORD);
        chk_data(32'(n_req - n0), 32'h0000_0002);
        access(bbx_pkg::BBX_OP_WRITE, 32'h4200_020C, 32'h0000_0001, bbx_pkg::BBX_SZ_WORD);
        access(bbx_pkg::BBX_OP_READ, 32'h4000_0010, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'hAA22_3348);
    endtask

    // SRAM alias base maps onto the SRAM bit-band base
    task automatic t_sram;
        access(bbx_pkg::BBX_OP_WRITE, 32'h2000_0000, 32'h0, bbx_pkg::BBX_SZ_WORD);
        access(bbx_pkg::BBX_OP_WRITE, 32'h2200_001C, 32'h0000_0001, bbx_pkg::BBX_SZ_WORD);
        access(bbx_pkg::BBX_OP_READ, 32'h2000_0000, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0080);
        access(bbx_pkg::BBX_OP_READ, 32'h2200_0000, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0000);
        access(bbx_pkg::BBX_OP_LDEX, 32'h2200_0000, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0000);
        access(bbx_pkg::BBX_OP_STEX, 32'h2200_0000, 32'h0000_0003, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0000);
        access(bbx_pkg::BBX_OP_READ, 32'h2000_0000, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0081);
    endtask

    // Refused fetch into the alias window, plain pass-through elsewhere
    task automatic t_fetch;
        n0 = n_req;
        access(bbx_pkg::BBX_OP_FETCH, 32'h4300_0004, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_flag(flt, 1'b1);
        chk_data(32'(n_req - n0), 32'h0000_0000);
        access(bbx_pkg::BBX_OP_WRITE, 32'h6000_0004, 32'hC0DE_0001, bbx_pkg::BBX_SZ_WORD);
        chk_data(last_req.addr, 32'h6000_0004);
        chk_data(last_req.wdata, 32'hC0DE_0001);
        chk_data(32'(n_req - n0), 32'h0000_0001);
        chk_flag(flt, 1'b0);
    endtask

    // Exclusive pairs in all sizes, tag drops and retry
    task automatic t_excl;
        bbx_pkg::bbx_size_t szs[3];
        logic [31:0]        exp_w[3];
        szs   = '{bbx_pkg::BBX_SZ_WORD, bbx_pkg::BBX_SZ_HALF, bbx_pkg::BBX_SZ_BYTE};
        exp_w = '{32'hA5A5_A5A5, 32'h0102_A5A5, 32'h0102_03A5};
        for (int i = 0; i < 3; i++) begin
            access(bbx_pkg::BBX_OP_WRITE, 32'h2000_0040, 32'h0102_0304, bbx_pkg::BBX_SZ_WORD);
            access(bbx_pkg::BBX_OP_LDEX, 32'h2000_0040, 32'h0, szs[i]);
            if (i == 0) chk_data(rdat, 32'h0102_0304);
            access(bbx_pkg::BBX_OP_STEX, 32'h2000_0040, 32'hA5A5_A5A5, szs[i]);
            chk_data(rdat, 32'h0000_0000);
            n0 = n_req;
            access(bbx_pkg::BBX_OP_STEX, 32'h2000_0040, 32'h0, szs[i]);
            chk_data(rdat, 32'h0000_0001);
            chk_data(32'(n_req - n0), 32'h0000_0000);
            access(bbx_pkg::BBX_OP_READ, 32'h2000_0040, 32'h0, bbx_pkg::BBX_SZ_WORD);
            chk_data(rdat, exp_w[i]);
        end
        for (int k = 0; k < 2; k++) begin
            access(bbx_pkg::BBX_OP_LDEX, 32'h2000_0040, 32'h0, bbx_pkg::BBX_SZ_WORD);
            pulse(k == 0);
            access(bbx_pkg::BBX_OP_STEX, 32'h2000_0040, 32'h0, bbx_pkg::BBX_SZ_WORD);
            if (k == 0) chk_data(rdat, 32'h0000_0001);
            else chk_data(rdat, 32'h0000_0001);
        end
        access(bbx_pkg::BBX_OP_LDEX, 32'h2000_0040, 32'h0, bbx_pkg::BBX_SZ_WORD);
        access(bbx_pkg::BBX_OP_STEX, 32'h2000_0040, 32'h0, bbx_pkg::BBX_SZ_WORD);
        chk_data(rdat, 32'h0000_0000);
    endtask

    // Closing report
    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        core_req_valid = 1'b0;
        core_req = '0;
        clear_exclusive_tag = 1'b0;
        exception_taken = 1'b0;
        slow = 1'b0;
        err_total = 0;
        tests_run = 0;
        n_req = 0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        t_direct;
        t_alias;
        t_sram;
        t_fetch;
        t_excl;
        give_verdict;
    end

    // Watchdog, well beyond the expected run of a few hundred cycles
    initial begin
        #50000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule
